// >>> hw/tcu_pkg.sv
/*
  Constants for the three-channel timer unit: register byte offsets, control
  field positions, reset values, service frame layout and bus responses.
  Assumes a single 200 MHz clock and an AXI4-Lite register bus.
*/
// Operation
// R1: Three independent timers, each with a 16-bit count advancing without CPU help.
// R2: One shared counter element serves timer 0, 1, 2, then an idle clock.
// R3: Register banks are shared by CPU and counter element with coherent results.
// R4: Pin event to output change takes two and a half to six and a half clocks.
// R5: Serviced event increments count, compares to active maximum, clears on match.
// R6: Dual mode alternates A and B maxima; otherwise A only; timer 2 A only.
// R7: Repeat clear stops the timer by clearing enable at sequence end.
// R8: Internal clocking counts every fourth clock, or timer 2 maxima when prescaled.
// R9: Internal clocking: rising pin retriggers, or pin level gates counting.
// R10: Pin clock mode counts synchronized rising pin edges, quarter clock rate at most.
// R11: Pin clock mode ignores retrigger and prescale; clear means internal clock.
// R12: Single mode output pulses per cycle; dual mode gives variable duty waveform.
// R13: Interrupt enable raises a request on every maximum-count match.
// R14: Timer 2 has no pins, counts every fourth clock, serves as prescaler.
// R15: Enable changes only when the write gate bit is set; gate reads zero.
// R16: Compare select flag reads one while B is active, zero while A.
// R17: Terminal count flag set by hardware, cleared only by software write.
// R18: Enable bits reset to zero so timers are stopped after reset.
// R19: Each timer has control, count and maximum registers; timers 0, 1 add B.
// R20: Software writes zero to reserved control bits.
// R21: Maximum zero counts 65536 events; maximum one counts one event.
// R22: Only equality is checked; a count above maximum wraps through zero.
// R23: Dual mode: A match selects B, B match selects A; output high in A.
// R24: Single mode output goes low for one service period at maximum count.
// R25: Input pins are synchronized and rising edges latched until serviced.
package tcu_pkg;
  // ==========================================================================
  // Register byte offsets
  localparam logic [7:0] OFF_T0_CTRL = 8'h00;
  localparam logic [7:0] OFF_T0_CNT = 8'h04;
  localparam logic [7:0] OFF_T0_CMPA = 8'h08;
  localparam logic [7:0] OFF_T0_CMPB = 8'h0c;
  localparam logic [7:0] OFF_T1_CTRL = 8'h10;
  localparam logic [7:0] OFF_T1_CNT = 8'h14;
  localparam logic [7:0] OFF_T1_CMPA = 8'h18;
  localparam logic [7:0] OFF_T1_CMPB = 8'h1c;
  localparam logic [7:0] OFF_T2_CTRL = 8'h20;
  localparam logic [7:0] OFF_T2_CNT = 8'h24;
  localparam logic [7:0] OFF_T2_CMPA = 8'h28;
  // ==========================================================================
  // Control field positions
  localparam int BIT_RUN = 0;
  localparam int BIT_DUAL = 1;
  localparam int BIT_PINCLK = 2;
  localparam int BIT_PRESC = 3;
  localparam int BIT_RTRG = 4;
  localparam int BIT_TCF = 5;
  localparam int BIT_CSEL = 12;
  localparam int BIT_IRQEN = 13;
  localparam int BIT_GATE = 14;
  localparam int BIT_EN = 15;
  // Plain stored bits written straight from the bus
  localparam logic [15:0] CTRL_WMASK01 = 16'h201f;
  localparam logic [15:0] CTRL_WMASK2 = 16'h2001;
  // ==========================================================================
  // Reset values and frame
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [15:0] CMP_RESET = 16'h0000;
  localparam logic [1:0] SLOT_T2 = 2'h2;
  localparam logic [1:0] SLOT_IDLE = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// >>> hw/tcu_timer_unit.sv
/*
  Three-channel 16-bit timer unit with one time-multiplexed counter element
  and an AXI4-Lite register slave.
  Assumes mclk at 200 MHz, asynchronous timer input pins, and one outstanding
  write and one outstanding read from the bus master.
*/
`timescale 1ns/100ps
module tcu_timer_unit #(
  parameter int ADDR_W = 8
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [1:0] timerInPin,
  output logic [1:0] timerOutPin,
  output logic [2:0] timerIrq
);
  import tcu_pkg::*;
  // ==========================================================================
  // Storage
  logic [15:0] ctrlFf [3];
  logic [15:0] cntFf [3];
  logic [15:0] cmpAFf [3];
  logic [15:0] cmpBFf [2];
  logic [1:0] slotFf;
  logic [1:0] edgePendFf;
  logic [1:0] t2HitFf;
  logic [1:0] pinLvl, pinRise;
  logic [1:0] pinOutFf;
  logic [2:0] irqFf;
  logic awHeldFf, wHeldFf, bvalidFf, rvalidFf;
  logic [ADDR_W-1:0] awAddrFf;
  logic [31:0] wDataFf;
  logic [3:0] wStrbFf;
  logic [1:0] brespFf, rrespFf;
  logic [31:0] rdataFf;

  // ==========================================================================
  // AXI4-Lite write path: address and data taken in either order
  logic wrDo;
  logic wrHit;
  assign s_axi_awready = !awHeldFf;
  assign s_axi_wready = !wHeldFf;
  assign wrDo = awHeldFf && wHeldFf && !bvalidFf;
  assign s_axi_bvalid = bvalidFf;
  assign s_axi_bresp = brespFf;

  // Offsets outside the map answer SLVERR
  function automatic logic isMapped(input logic [ADDR_W-1:0] a);
    logic [7:0] b;
    b = 8'(a);
    isMapped = (b[1:0] == 2'h0) && (b <= OFF_T2_CMPA) && (a[ADDR_W-1:2] == (ADDR_W-2)'(b[7:2]));
  endfunction

  // Byte lanes above bit 15 carry nothing
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  assign wrHit = wrDo && isMapped(awAddrFf);

  // Hold each channel until the pair completes
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      awHeldFf <= 1'b0;
      wHeldFf <= 1'b0;
      bvalidFf <= 1'b0;
      awAddrFf <= '0;
      wDataFf <= 32'h0;
      wStrbFf <= 4'h0;
      brespFf <= RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && !awHeldFf)
      begin
        awHeldFf <= 1'b1;
        awAddrFf <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !wHeldFf)
      begin
        wHeldFf <= 1'b1;
        wDataFf <= s_axi_wdata;
        wStrbFf <= s_axi_wstrb;
      end
      if (wrDo)
      begin
        bvalidFf <= 1'b1;
        brespFf <= isMapped(awAddrFf) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bvalidFf && s_axi_bready)
      begin
        bvalidFf <= 1'b0;
        awHeldFf <= 1'b0; // Channels reopen only after the response is taken
        wHeldFf <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Input pin synchronizers and edge latches
  genvar gp;
  generate
    for (gp = 0; gp < 2; gp++)
    begin : g_pin
      logic syncAFf, syncBFf, prevFf;
      assign pinLvl[gp] = syncBFf;
      assign pinRise[gp] = syncBFf && !prevFf;
      // A fresh edge meets its own slot at once; the latch only covers the wait
      always_ff @(posedge mclk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          syncAFf <= 1'b0;
          syncBFf <= 1'b0;
          prevFf <= 1'b0;
          edgePendFf[gp] <= 1'b0;
        end
        else
        begin
          syncAFf <= timerInPin[gp]; // R25
          syncBFf <= syncAFf;
          prevFf <= syncBFf;
          if (slotFf == 2'(gp))
            edgePendFf[gp] <= 1'b0;
          else if (pinRise[gp])
            edgePendFf[gp] <= 1'b1; // R25
        end
      end
    end
  endgenerate

  // ==========================================================================
  // Service frame: timer 0, timer 1, timer 2, idle
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      slotFf <= 2'h0;
    else
      slotFf <= slotFf + 2'h1; // R2
  end

  // ==========================================================================
  // Shared counter element
  logic svcValid, isPinTmr, pinClk, rtrg, presc, dual, edgeSeen, tick, gateOk;
  logic retrig, qual, match, endSeq, nxtCsel;
  logic [1:0] idx;
  logic [15:0] curCtrl, curCnt, curMax, incr, nxtCnt;

  always_comb
  begin
    idx = (slotFf == SLOT_IDLE) ? 2'h0 : slotFf;
    svcValid = (slotFf != SLOT_IDLE); // R2
    isPinTmr = (slotFf != SLOT_T2) && svcValid; // R14
    curCtrl = ctrlFf[idx];
    curCnt = cntFf[idx];
    dual = isPinTmr && curCtrl[BIT_DUAL];
    curMax = (dual && curCtrl[BIT_CSEL]) ? cmpBFf[idx[0]] : cmpAFf[idx]; // R6
    pinClk = isPinTmr && curCtrl[BIT_PINCLK];
    rtrg = isPinTmr && !pinClk && curCtrl[BIT_RTRG]; // R11
    presc = isPinTmr && !pinClk && curCtrl[BIT_PRESC]; // R11
    edgeSeen = isPinTmr && (edgePendFf[idx[0]] || pinRise[idx[0]]); // R4 R25
    retrig = svcValid && curCtrl[BIT_EN] && rtrg && edgeSeen; // R9
    gateOk = !isPinTmr || pinClk || rtrg || pinLvl[idx[0]]; // R9
    tick = pinClk ? edgeSeen : (presc ? t2HitFf[idx[0]] : 1'b1); // R8 R10
    qual = svcValid && curCtrl[BIT_EN] && !retrig && gateOk && tick; // R5
    incr = curCnt + 16'h1; // R22
    match = qual && (incr == curMax); // R21 R22
    endSeq = match && (!dual || curCtrl[BIT_CSEL]);
    nxtCsel = (match && dual) ? !curCtrl[BIT_CSEL] : curCtrl[BIT_CSEL]; // R23
    if (retrig || match)
      nxtCnt = 16'h0; // R5
    else if (qual)
      nxtCnt = incr;
    else
      nxtCnt = curCnt;
  end

  // Timer 2 maxima wait for each prescaled timer's own slot
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      t2HitFf <= 2'h0;
    else
    begin
      for (int i = 0; i < 2; i++)
      begin
        if (match && slotFf == SLOT_T2)
          t2HitFf[i] <= 1'b1; // R8 R14
        else if (slotFf == 2'(i))
          t2HitFf[i] <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Count and maximum registers; a CPU write wins over the element's writeback
  logic [7:0] wAddr8;
  assign wAddr8 = 8'(awAddrFf);

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < 3; i++)
      begin
        cntFf[i] <= CNT_RESET;
        cmpAFf[i] <= CMP_RESET;
      end
      cmpBFf[0] <= CMP_RESET;
      cmpBFf[1] <= CMP_RESET;
    end
    else
    begin
      if (svcValid)
        cntFf[idx] <= nxtCnt; // R1 R5
      if (wrHit)
      begin
        case (wAddr8)
          OFF_T0_CNT: cntFf[0] <= merge16(cntFf[0], wDataFf, wStrbFf); // R3
          OFF_T1_CNT: cntFf[1] <= merge16(cntFf[1], wDataFf, wStrbFf);
          OFF_T2_CNT: cntFf[2] <= merge16(cntFf[2], wDataFf, wStrbFf);
          OFF_T0_CMPA: cmpAFf[0] <= merge16(cmpAFf[0], wDataFf, wStrbFf); // R19
          OFF_T1_CMPA: cmpAFf[1] <= merge16(cmpAFf[1], wDataFf, wStrbFf);
          OFF_T2_CMPA: cmpAFf[2] <= merge16(cmpAFf[2], wDataFf, wStrbFf);
          OFF_T0_CMPB: cmpBFf[0] <= merge16(cmpBFf[0], wDataFf, wStrbFf);
          OFF_T1_CMPB: cmpBFf[1] <= merge16(cmpBFf[1], wDataFf, wStrbFf);
          default: ;
        endcase
      end
    end
  end

  // ==========================================================================
  // Control registers, one per timer
  logic [7:0] ctrlOff [3];
  assign ctrlOff[0] = OFF_T0_CTRL;
  assign ctrlOff[1] = OFF_T1_CTRL;
  assign ctrlOff[2] = OFF_T2_CTRL;

  genvar gc;
  generate
    for (gc = 0; gc < 3; gc++)
    begin : g_ctrl
      localparam logic [15:0] WMASK = (gc == 2) ? CTRL_WMASK2 : CTRL_WMASK01;
      logic cpuWr, hwSvc;
      logic [15:0] wv;
      assign cpuWr = wrHit && (wAddr8 == ctrlOff[gc]);
      assign hwSvc = svcValid && (idx == 2'(gc));
      assign wv = merge16(ctrlFf[gc], wDataFf, wStrbFf);
      // Gate bit is never stored; flag set beats a same-cycle clear
      always_ff @(posedge mclk or negedge rst_n)
      begin
        if (!rst_n)
          ctrlFf[gc] <= CTRL_RESET; // R18
        else
        begin
          if (cpuWr)
          begin
            ctrlFf[gc] <= (ctrlFf[gc] & ~WMASK) | (wv & WMASK); // R20
            ctrlFf[gc][BIT_TCF] <= wv[BIT_TCF] || (hwSvc && match); // R17
            if (wv[BIT_GATE])
              ctrlFf[gc][BIT_EN] <= wv[BIT_EN]; // R15
            else if (hwSvc && endSeq && !curCtrl[BIT_RUN])
              ctrlFf[gc][BIT_EN] <= 1'b0;
            if (hwSvc)
              ctrlFf[gc][BIT_CSEL] <= nxtCsel;
          end
          else if (hwSvc)
          begin
            if (match)
              ctrlFf[gc][BIT_TCF] <= 1'b1; // R17
            if (endSeq && !curCtrl[BIT_RUN])
              ctrlFf[gc][BIT_EN] <= 1'b0; // R7
            ctrlFf[gc][BIT_CSEL] <= nxtCsel; // R16 R23
          end
        end
      end
    end
  endgenerate

  // ==========================================================================
  // Output pins and interrupt requests
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pinOutFf <= 2'h3;
      irqFf <= 3'h0;
    end
    else
    begin
      irqFf <= 3'h0;
      if (svcValid)
        irqFf[idx] <= match && curCtrl[BIT_IRQEN]; // R13
      if (isPinTmr)
      begin
        if (dual)
          pinOutFf[idx[0]] <= !nxtCsel; // R12 R23
        else
          pinOutFf[idx[0]] <= !match; // R12 R24
      end
    end
  end
  assign timerOutPin = pinOutFf; // R4
  assign timerIrq = irqFf;

  // ==========================================================================
  // AXI4-Lite read path
  logic [15:0] rdVal;
  logic [7:0] rAddr8;
  assign rAddr8 = 8'(s_axi_araddr);
  assign s_axi_arready = !rvalidFf;
  assign s_axi_rvalid = rvalidFf;
  assign s_axi_rdata = rdataFf;
  assign s_axi_rresp = rrespFf;

  // Gate bit always reads as zero
  always_comb
  begin
    case (rAddr8)
      OFF_T0_CTRL: rdVal = ctrlFf[0]; // R15 R16
      OFF_T1_CTRL: rdVal = ctrlFf[1];
      OFF_T2_CTRL: rdVal = ctrlFf[2];
      OFF_T0_CNT: rdVal = cntFf[0];
      OFF_T1_CNT: rdVal = cntFf[1];
      OFF_T2_CNT: rdVal = cntFf[2];
      OFF_T0_CMPA: rdVal = cmpAFf[0];
      OFF_T1_CMPA: rdVal = cmpAFf[1];
      OFF_T2_CMPA: rdVal = cmpAFf[2];
      OFF_T0_CMPB: rdVal = cmpBFf[0];
      OFF_T1_CMPB: rdVal = cmpBFf[1];
      default: rdVal = 16'h0;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rvalidFf <= 1'b0;
      rdataFf <= 32'h0;
      rrespFf <= RESP_OKAY;
    end
    else if (s_axi_arvalid && !rvalidFf)
    begin
      rvalidFf <= 1'b1;
      rdataFf <= {16'h0, isMapped(s_axi_araddr) ? rdVal : 16'h0};
      rrespFf <= isMapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (rvalidFf && s_axi_rready)
      rvalidFf <= 1'b0;
  end

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  a_slot_frame_step: assert property (slotFf == SLOT_IDLE |=> slotFf == 2'h0 ##1 slotFf == 2'h1 ##1 slotFf == SLOT_T2)
    else $error("service frame out of order"); // R2
  a_idle_count_hold: assert property (slotFf == SLOT_IDLE && !wrHit |=> cntFf[0] == $past(cntFf[0]))
    else $error("count moved in idle slot"); // R1
  a_match_clears_cnt: assert property (match && !wrHit |=> cntFf[$past(idx)] == 16'h0)
    else $error("count not cleared at maximum"); // R5
  a_gate_reads_zero: assert property (rvalidFf |-> !rdataFf[BIT_GATE])
    else $error("write gate read back as one"); // R15
  a_en_needs_gate: assert property ($rose(ctrlFf[0][BIT_EN]) |-> $past(wrHit && wAddr8 == OFF_T0_CTRL && wDataFf[BIT_GATE]))
    else $error("enable set without gate"); // R15
  a_flag_only_sw: assert property ($fell(ctrlFf[1][BIT_TCF]) |-> $past(wrHit && wAddr8 == OFF_T1_CTRL))
    else $error("terminal flag cleared by hardware"); // R17
  a_single_stop: assert property (slotFf == 2'h0 && endSeq && !curCtrl[BIT_RUN] && !wrHit |=> !ctrlFf[0][BIT_EN])
    else $error("timer kept running after sequence"); // R7
  a_dual_out_phase: assert property (slotFf == 2'h0 && dual |=> timerOutPin[0] == !ctrlFf[0][BIT_CSEL] [*4])
    else $error("dual output not following compare phase"); // R23
  a_single_pulse_len: assert property (slotFf == 2'h0 && !dual && match |=>
    !timerOutPin[0] [*4] ##1 (timerOutPin[0] || $past(match)))
    else $error("single mode pulse length wrong"); // R24
  a_irq_needs_en: assert property (timerIrq[2] |-> $past(ctrlFf[2][BIT_IRQEN] && match))
    else $error("interrupt without enable and match"); // R13
  a_bvalid_hold: assert property (bvalidFf && !s_axi_bready |=> bvalidFf)
    else $error("write response dropped");

  c_prescaled_tick: cover property (slotFf == 2'h1 && presc && qual);
  c_retrigger: cover property (retrig);
  c_dual_swap: cover property (match && dual && curCtrl[BIT_CSEL]);
  c_pin_clock: cover property (pinClk && match);
endmodule

// >>> test/tcu_pin_model.sv
/*
  Model of the outside logic that drives the two timer input pins.
  Assumes the bench asks for a pulse with a one-cycle strobe on mclk.
*/
`timescale 1ns/100ps
module tcu_pin_model (
  input wire logic mclk,
  input wire logic [1:0] pulseGo,
  input wire logic [1:0] holdHigh,
  output logic [1:0] timerInPin
);
  logic [3:0] phaseFf [2] = '{4'h0, 4'h0};
  // ==========================================================================
  // Pulse shaping
  // Four clocks high then at least five low, so edges never come faster than the pin allows
  always @(posedge mclk)
  begin
    for (int i = 0; i < 2; i++)
    begin
      if (phaseFf[i] != 4'h0)
        phaseFf[i] <= phaseFf[i] - 4'h1;
      else if (pulseGo[i])
        phaseFf[i] <= 4'h8;
    end
  end
  // Held level acts as the gate; the pulse gives the counted edge
  assign timerInPin = holdHigh | {phaseFf[1] > 4'h4, phaseFf[0] > 4'h4};
endmodule

// >>> test/three_channel_timer_unit_tb.sv
/*
  Self-checking bench for the timer unit: register access over AXI4-Lite,
  counting modes, pin clocking and output waveforms.
  Assumes the pin model drives the timer inputs and a 200 MHz mclk.
*/
`timescale 1ns/100ps
module three_channel_timer_unit_tb;
  import tcu_pkg::*;
  localparam logic [15:0] RUN = 16'h1 << BIT_RUN;
  localparam logic [15:0] DUAL = 16'h1 << BIT_DUAL;
  localparam logic [15:0] PCLK = 16'h1 << BIT_PINCLK;
  localparam logic [15:0] PRE = 16'h1 << BIT_PRESC;
  localparam logic [15:0] INPUT_RETRIGGER = 16'h1 << BIT_RTRG;
  localparam logic [15:0] TCF = 16'h1 << BIT_TCF;
  localparam logic [15:0] CSEL = 16'h1 << BIT_CSEL;
  localparam logic [15:0] IRQ = 16'h1 << BIT_IRQEN;
  localparam logic [15:0] GATE = 16'h1 << BIT_GATE;
  localparam logic [15:0] EN = 16'h1 << BIT_EN;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h3;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [31:0] s_axi_rdata;
  logic [1:0] timerInPin, timerOutPin;
  logic [1:0] pulseGo = 2'b00;
  logic [1:0] holdHigh = 2'b00;
  logic [1:0] prevOut = 2'b11;
  logic [2:0] timerIrq;
  logic [15:0] rdv, rdw;
  logic mon = 1'b0;
  int errCount = 0;
  int comparisons = 0;
  int lat;
  int irqCnt [3];
  int lowCnt [2];
  int fallCnt [2];

  // ==========================================================================
  // Clock, design and pin model
  always #2.5 mclk = ~mclk;
  tcu_timer_unit #(.ADDR_W(8)) u_dut (.mclk(mclk), .rst_n(rst_n),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .timerInPin(timerInPin),
    .timerOutPin(timerOutPin), .timerIrq(timerIrq));
  tcu_pin_model u_pins (.mclk(mclk), .pulseGo(pulseGo), .holdHigh(holdHigh), .timerInPin(timerInPin));

  // ==========================================================================
  // Output monitor, counting only inside a window so boundaries stay exact
  always @(posedge mclk)
  begin
    for (int i = 0; i < 3; i++)
      if (mon && timerIrq[i] === 1'b1)
        irqCnt[i]++;
    for (int i = 0; i < 2; i++)
      if (mon && timerOutPin[i] === 1'b0)
      begin
        lowCnt[i]++;
        if (prevOut[i] === 1'b1)
          fallCnt[i]++;
      end
    prevOut <= timerOutPin;
  end

  // ==========================================================================
  // Tasks
  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      errCount++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Reserved control bits are always written as zero
  task wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge mclk);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge mclk);
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata[15:0];
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task pulse(input logic [1:0] p);
    @(posedge mclk);
    pulseGo <= p;
    @(posedge mclk);
    pulseGo <= 2'b00;
  endtask

  // Counters are cleared while the monitor is off, so no race with it
  task window(input int n);
    irqCnt = '{0, 0, 0};
    lowCnt = '{0, 0};
    fallCnt = '{0, 0};
    @(posedge mclk);
    mon <= 1'b1;
    repeat (n) @(posedge mclk);
    mon <= 1'b0;
  endtask

  task wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, errCount);
    if (errCount == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ==========================================================================
  // Watchdog, well beyond the roughly 1300 cycles the tests need
  initial
  begin
    repeat (20000) @(posedge mclk);
    errCount++;
    wrap_up;
  end

  // ==========================================================================
  // Test sequence
  initial
  begin
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    // Reset values, register map and unmapped places
    for (int a = 0; a <= 'h28; a += 4)
    begin
      rd(8'(a), rdv);
      chk("reset value", {resp, rdv}, 32'h0);
    end
    rd(8'h2c, rdv);
    chk("unmapped read", {resp, rdv}, {RESP_SLVERR, 16'h0000});
    wr(8'h2c, 16'h0001);
    chk("unmapped write", resp, RESP_SLVERR);
    // Enable moves only with the gate bit, and the gate reads zero
    wr(OFF_T0_CTRL, EN);
    rd(OFF_T0_CTRL, rdv);
    chk("ungated enable", rdv, 16'h0000);
    wr(OFF_T0_CTRL, EN | GATE);
    rd(OFF_T0_CTRL, rdv);
    chk("gated enable", rdv, EN);
    wr(OFF_T0_CTRL, GATE);
    // Single shot: one pulse, one request, then hardware stops the timer
    holdHigh <= 2'b11;
    wr(OFF_T0_CMPA, 16'h0003);
    wr(OFF_T0_CNT, 16'h0000);
    wr(OFF_T0_CTRL, IRQ | GATE | EN);
    window(100);
    rd(OFF_T0_CTRL, rdv);
    chk("single stop", rdv, IRQ | TCF);
    rd(OFF_T0_CNT, rdv);
    chk("count cleared", rdv, 16'h0000);
    chk("single irq", irqCnt[0], 1);
    chk("single low", lowCnt[0], 4);
    wr(OFF_T0_CTRL, IRQ);
    rd(OFF_T0_CTRL, rdv);
    chk("flag cleared", rdv, IRQ);
    // Dual mode: A=2, B=3 gives a 20-clock cycle, low for the 12 of B
    wr(OFF_T1_CMPA, 16'h0002);
    wr(OFF_T1_CMPB, 16'h0003);
    wr(OFF_T1_CNT, 16'h0000);
    wr(OFF_T1_CTRL, IRQ | DUAL | RUN | GATE | EN);
    repeat (40) @(posedge mclk);
    window(400);
    chk("dual irq", irqCnt[1], 40);
    chk("dual falls", fallCnt[1], 20);
    chk("dual low", lowCnt[1], 240);
    // Prescaled by timer 2 (max 4): one step per 16 clocks, reads 320 apart
    wr(OFF_T2_CMPA, 16'h0004);
    wr(OFF_T2_CNT, 16'h0000);
    wr(OFF_T1_CNT, 16'h0000);
    wr(OFF_T1_CMPA, 16'h0000);
    wr(OFF_T1_CTRL, PRE | RUN | GATE | EN);
    wr(OFF_T2_CTRL, IRQ | RUN | GATE | EN);
    repeat (20) @(posedge mclk);
    rd(OFF_T1_CNT, rdv);
    window(316);
    rd(OFF_T1_CNT, rdw);
    chk("prescaled steps", 16'(rdw - rdv), 16'd20);
    chk("no irq when disabled", irqCnt[1], 0);
    chk("timer 2 irq", (irqCnt[2] >= 19 && irqCnt[2] <= 20), 1);
    // Pin level low gates the count off
    holdHigh <= 2'b00;
    repeat (20) @(posedge mclk);
    rd(OFF_T1_CNT, rdv);
    repeat (100) @(posedge mclk);
    rd(OFF_T1_CNT, rdw);
    chk("gated off", 16'(rdw - rdv), 16'd0);
    // Retrigger: a rising pin clears the count instead of gating it
    wr(OFF_T1_CNT, 16'h0100);
    wr(OFF_T1_CTRL, INPUT_RETRIGGER | RUN | GATE | EN);
    pulse(2'b10);
    repeat (8) @(posedge mclk);
    rd(OFF_T1_CNT, rdv);
    chk("retrigger", (rdv < 16'h0010), 1);
    wr(OFF_T1_CTRL, GATE);
    wr(OFF_T2_CTRL, GATE);
    // Pin clocking ignores retrigger and prescale; measure pin to output delay
    wr(OFF_T0_CMPA, 16'h0003);
    wr(OFF_T0_CNT, 16'h0000);
    wr(OFF_T0_CTRL, PCLK | PRE | INPUT_RETRIGGER | RUN | GATE | EN);
    repeat (2)
    begin
      pulse(2'b01);
      repeat (12) @(posedge mclk);
    end
    rd(OFF_T0_CNT, rdv);
    chk("pin edges", rdv, 16'h0002);
    pulse(2'b01);
    lat = 0;
    while (timerOutPin[0] !== 1'b0 && lat < 20)
    begin
      @(posedge mclk);
      lat++;
    end
    chk("pin latency", (lat >= 4 && lat <= 7), 1);
    repeat (12) @(posedge mclk);
    rd(OFF_T0_CTRL, rdv);
    chk("pin match", rdv, PCLK | PRE | INPUT_RETRIGGER | RUN | TCF | EN);
    // Dual on pin clock: A=1 then B=5 shows the select flag both ways
    wr(OFF_T0_CMPA, 16'h0001);
    wr(OFF_T0_CMPB, 16'h0005);
    wr(OFF_T0_CNT, 16'h0000);
    wr(OFF_T0_CTRL, PCLK | DUAL | RUN | GATE | EN);
    pulse(2'b01);
    repeat (12) @(posedge mclk);
    rd(OFF_T0_CTRL, rdv);
    chk("select B", rdv, CSEL | PCLK | DUAL | RUN | TCF | EN);
    chk("B phase out", timerOutPin[0], 1'b0);
    repeat (5)
    begin
      pulse(2'b01);
      repeat (10) @(posedge mclk);
    end
    rd(OFF_T0_CTRL, rdv);
    chk("select A", rdv, PCLK | DUAL | RUN | TCF | EN);
    chk("A phase out", timerOutPin[0], 1'b1);
    wrap_up;
  end
endmodule
